// ===== logic/dccrc_unit.v
// dccrc_unit.v: crc-32 generator of one dma channel, with post-transfer
// control, ahb-lite register slave and a masked interrupt.
// assumes datapath events are on I_CLK and the channel data path sends
// the crc word when o_post_req pulses and answers with i_post_ack.
`default_nettype none

module dccrc_unit
(
    // clock, reset, enable
    input wire I_CLK,
    input wire I_RST_N,
    input wire I_CE,
    // ahb-lite slave
    input wire I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    output reg [31:0] O_HRDATA,
    output reg O_HREADYOUT,
    output reg O_HRESP,
    // channel datapath events, one-cycle pulses
    input wire I_XFER_START,
    input wire I_DATA_VALID,
    input wire [31:0] I_DATA,
    input wire [2:0] I_DATA_BYTES,
    input wire I_ADDR_REACHED_END,
    input wire I_FW_ABORT,
    input wire I_BUS_ERROR,
    input wire I_TARGET_TERMINATE,
    // post-transfer to target
    output reg O_POST_REQ,
    output reg [31:0] O_POST_DATA,
    input wire I_POST_ACK,
    // interrupt
    output reg O_IRQ
);
`include "dccrc_defs.vh"

    localparam ST_IDLE = 2'h0;
    localparam ST_POST = 2'h1;

    function [31:0] rev32;
        input [31:0] v;
        integer i;
        begin
            for (i = 0; i < 32; i = i + 1)
                rev32[i] = v[31-i];
        end
    endfunction

    reg [1:0] enable;
    reg [31:0] crc;
    reg [3:0] post_stat;
    reg [3:0] irq_stat;
    reg [3:0] irq_mask;
    reg [1:0] state;
    reg ap_write;
    reg ap_valid;
    reg [7:0] ap_addr;
    reg [31:0] next_crc_rd;
    reg [3:0] next_irq_stat;
    wire [31:0] crc_upd;
    // generator state is kept bit-reversed, so the register read form
    // of inverted-and-reversed comes out as the standard crc-32 result
    wire [31:0] crc_refl;

    assign crc_refl = rev32(crc);

    dccrc_byte u_byte
    (
        .i_state(crc_refl),
        .i_data(I_DATA),
        .i_nbytes(I_DATA_BYTES),
        .o_state(crc_upd)
    );

    wire ap_take = I_HSEL && I_HREADY && I_HTRANS[1];
    wire wr_en = ap_valid && ap_write;
    // normal end excludes flow-control terminate, abort and bus error
    wire normal_end = I_ADDR_REACHED_END && !I_TARGET_TERMINATE
        && !I_FW_ABORT && !I_BUS_ERROR;
    wire any_end = I_ADDR_REACHED_END || I_TARGET_TERMINATE
        || I_FW_ABORT || I_BUS_ERROR;
    wire post_go = (state == ST_IDLE) && normal_end
        && enable[`DCCRC_EN_POST];
    wire post_end = (state == ST_POST) && I_POST_ACK;

    // events feeding interrupt status: calc done, post done
    wire [3:0] ev;
    assign ev = {2'b00, post_end, any_end};

    // a read of the crc value right behind a write to it sees the written value
    always @*
    begin
        next_crc_rd = crc;
        if (wr_en && ap_addr == `DCCRC_OFF_VALUE)
            next_crc_rd = I_HWDATA;
    end

    // read word picked in the address phase, registered into the data
    // phase; unmapped offsets and reserved bits give zero
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (I_HADDR[7:0])
            `DCCRC_OFF_ENABLE: rd_mux = {30'h0, enable};
            `DCCRC_OFF_VALUE: rd_mux = ~rev32(next_crc_rd);
            `DCCRC_OFF_POST: rd_mux = {28'h0, post_stat};
            `DCCRC_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            `DCCRC_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // interrupt status after this edge: set wins over write-one-clear
    always @*
    begin
        next_irq_stat = irq_stat | ev;
        if (wr_en && ap_addr == `DCCRC_OFF_IRQ_STAT)
            next_irq_stat = (irq_stat & ~I_HWDATA[3:0]) | ev;
    end

    // bus slave: zero wait states, always okay
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end
        else if (I_CE)
        begin
            ap_valid <= ap_take;
            if (ap_take)
            begin
                ap_write <= I_HWRITE;
                ap_addr <= I_HADDR[7:0];
            end
            // read data registered from the address phase directly
            if (ap_take && !I_HWRITE)
                O_HRDATA <= rd_mux;
        end
    end

    // control registers and generator
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            enable <= `DCCRC_RST_ENABLE;
            crc <= `DCCRC_RST_VALUE;
            irq_mask <= 4'h0;
        end
        else if (I_CE)
        begin
            if (wr_en && ap_addr == `DCCRC_OFF_ENABLE)
                enable <= I_HWDATA[1:0];
            if (wr_en && ap_addr == `DCCRC_OFF_IRQ_MASK)
                irq_mask <= I_HWDATA[3:0];
            // start of a transaction leaves crc alone
            if (wr_en && ap_addr == `DCCRC_OFF_VALUE)
                crc <= I_HWDATA;
            else if (I_DATA_VALID && enable[`DCCRC_EN_CALC])
                crc <= rev32(crc_upd);
        end
    end

    // post-transfer sequencer and status
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state <= ST_IDLE;
            post_stat <= 4'h0;
            O_POST_REQ <= 1'b0;
            O_POST_DATA <= 32'h0000_0000;
        end
        else if (I_CE)
        begin
            O_POST_REQ <= 1'b0;
            if (I_XFER_START)
            begin
                post_stat[`DCCRC_ST_CALC_DONE] <= 1'b0;
                post_stat[`DCCRC_ST_DATA_DONE] <= 1'b0;
            end
            if (any_end)
                post_stat[`DCCRC_ST_CALC_DONE] <= 1'b1;
            case (state)
                ST_IDLE:
                begin
                    if (post_go)
                    begin
                        state <= ST_POST;
                        O_POST_REQ <= 1'b1;
                        O_POST_DATA <= ~rev32(crc);
                        post_stat[`DCCRC_ST_RUNNING] <= 1'b1;
                        post_stat[`DCCRC_ST_DATA_READY] <= 1'b1;
                    end
                end
                ST_POST:
                begin
                    if (I_POST_ACK)
                    begin
                        state <= ST_IDLE;
                        post_stat[`DCCRC_ST_RUNNING] <= 1'b0;
                        post_stat[`DCCRC_ST_DATA_READY] <= 1'b0;
                        post_stat[`DCCRC_ST_DATA_DONE] <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // sticky interrupt status: set wins over write-one-clear
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            irq_stat <= 4'h0;
            O_IRQ <= 1'b0;
        end
        else if (I_CE)
        begin
            irq_stat <= next_irq_stat;
            // level follows the status that this edge stores, so a
            // clear drops the line without an extra stale cycle
            O_IRQ <= |(next_irq_stat & irq_mask);
        end
    end

endmodule // dccrc_unit

`default_nettype wire

// ===== common/dccrc_defs.vh
// dccrc_defs.vh: offsets, field positions, reset values and polynomial
// for the per-channel crc-32 unit; included by the design files.
`ifndef DCCRC_DEFS_VH
`define DCCRC_DEFS_VH

`define DCCRC_OFF_ENABLE 8'h20
`define DCCRC_OFF_VALUE 8'h24
`define DCCRC_OFF_POST 8'h28
`define DCCRC_OFF_IRQ_STAT 8'h2C
`define DCCRC_OFF_IRQ_MASK 8'h30

`define DCCRC_EN_CALC 0
`define DCCRC_EN_POST 1
`define DCCRC_ST_CALC_DONE 0
`define DCCRC_ST_RUNNING 1
`define DCCRC_ST_DATA_DONE 2
`define DCCRC_ST_DATA_READY 3

`define DCCRC_RST_ENABLE 2'h0
`define DCCRC_RST_VALUE 32'h0000_0000
`define DCCRC_POLY 32'hEDB8_8320

`endif

// ===== logic/dccrc_byte.v
// dccrc_byte.v: combinational crc-32 update over up to four bytes.
// assumes the caller registers the result; no state held here.
`default_nettype none

module dccrc_byte
(
    // state in
    input wire [31:0] i_state,
    // data in, low byte first
    input wire [31:0] i_data,
    input wire [2:0] i_nbytes,
    // next state
    output reg [31:0] o_state
);
`include "dccrc_defs.vh"

    integer b;
    integer k;
    reg [31:0] s;

    always @*
    begin
        s = i_state;
        for (b = 0; b < 4; b = b + 1)
        begin
            if (b < i_nbytes)
            begin
                for (k = 0; k < 8; k = k + 1)
                begin
                    // reflected form, lsb of each byte first
                    if (s[0] ^ i_data[8*b+k])
                        s = (s >> 1) ^ `DCCRC_POLY;
                    else
                        s = s >> 1;
                end
            end
        end
        o_state = s;
    end

endmodule // dccrc_byte

`default_nettype wire

// ===== verif/dccrc_unit_assertions.sv
// dccrc_unit_assertions.sv: port checks on the crc unit.
// assumes it is bound to dccrc_unit; one clock domain.
`default_nettype none
module dccrc_chk (
    input wire logic I_CLK, I_RST_N, I_CE, I_HSEL, I_HWRITE, I_HREADY,
    input wire logic [1:0] I_HTRANS,
    input wire logic [31:0] I_HADDR, O_HRDATA, O_POST_DATA,
    input wire logic I_ADDR_REACHED_END, I_FW_ABORT, I_BUS_ERROR,
    input wire logic I_TARGET_TERMINATE, I_POST_ACK, O_POST_REQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    logic busy;
    wire logic rd = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_CE;
    // post in flight from request until the target acks
    always @(posedge I_CLK or negedge I_RST_N)
        if (!I_RST_N) busy <= 1'b0;
        else if (O_POST_REQ) busy <= 1'b1;
        else if (I_POST_ACK) busy <= 1'b0;
    post_abort_a: assert property ((I_FW_ABORT || I_BUS_ERROR)
        |=> !O_POST_REQ) else $error("post after abort");
    post_term_a: assert property (I_TARGET_TERMINATE
        |=> !O_POST_REQ) else $error("post after target end");
    post_cause_a: assert property (O_POST_REQ |->
        $past(I_ADDR_REACHED_END)) else $error("post without end");
    post_pulse_a: assert property (O_POST_REQ |=> !O_POST_REQ)
        else $error("post request held");
    post_busy_a: assert property (busy && !I_POST_ACK &&
        I_ADDR_REACHED_END |=> !O_POST_REQ) else $error("second post");
    post_data_a: assert property (!O_POST_REQ |->
        $stable(O_POST_DATA)) else $error("post data moved");
    unmapped_rd_a: assert property (rd && (I_HADDR[7:0] < 8'h20 ||
        I_HADDR[7:0] > 8'h30) |=> O_HRDATA == 32'h0)
        else $error("unmapped read not zero");
    state_rsv_a: assert property (rd && I_HADDR[7:0] == 8'h28 |=>
        O_HRDATA[31:4] == 28'h0) else $error("status reserved set");
endmodule // dccrc_chk
bind dccrc_unit dccrc_chk dccrc_chk_inst (.I_CLK, .I_RST_N, .I_CE, .I_HSEL,
    .I_HWRITE, .I_HREADY, .I_HTRANS, .I_HADDR, .O_HRDATA, .O_POST_DATA,
    .I_ADDR_REACHED_END, .I_FW_ABORT, .I_BUS_ERROR, .I_TARGET_TERMINATE,
    .I_POST_ACK, .O_POST_REQ);
`default_nettype wire

// ===== verif/dccrc_target.sv
// dccrc_target.sv: channel target taking the posted crc word.
// assumes one request at a time; acks after a set delay.
`default_nettype none
module dccrc_target (
    input wire logic clk, rst_n, req,
    input wire logic [31:0] data,
    input wire logic [3:0] delay,
    output logic ack,
    output logic [31:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    always @(posedge clk or negedge rst_n)
        if (!rst_n) {busy, ack, cnt, got} <= '0;
        else
        begin
            ack <= req ? 1'b0 : busy && cnt == 4'h0;
            if (req) {busy, cnt, got} <= {1'b1, delay, data};
            else if (busy && cnt == 4'h0) busy <= 1'b0;
            else if (busy) cnt <= cnt - 4'h1;
        end
endmodule // dccrc_target
`default_nettype wire

// ===== verif/tb.sv
// tb.sv: self-checking bench for the crc unit over ahb-lite.
// assumes the target model acks every post request.
`default_nettype none
`include "dccrc_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, dv = 0, rd_ph = 0;
    logic [1:0] htrans = 0;
    logic [7:0] haddr = 0;
    logic [4:0] ev = 0;
    logic [2:0] nb = 1;
    logic [3:0] dly = 0;
    logic [31:0] hwdata = 0, data = 0, hrdata, pdata, got, w, q;
    logic hready, hresp, preq, ack, irq;
    logic [31:0] rq[$], pq[$];
    int n_mismatch = 0, num_checks = 0, i;
    always #5 clk = ~clk;
    dccrc_unit dccrc_unit_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
        .I_HSEL(hsel), .I_HADDR({24'h0, haddr}), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
        .O_HRESP(hresp), .I_XFER_START(ev[0]), .I_DATA_VALID(dv),
        .I_DATA(data), .I_DATA_BYTES(nb), .I_ADDR_REACHED_END(ev[1]),
        .I_FW_ABORT(ev[2]), .I_BUS_ERROR(ev[3]),
        .I_TARGET_TERMINATE(ev[4]), .O_POST_REQ(preq),
        .O_POST_DATA(pdata), .I_POST_ACK(ack), .O_IRQ(irq));
    dccrc_target dccrc_target_inst (.clk(clk), .rst_n(rst_n), .req(preq),
        .data(pdata), .delay(dly), .ack(ack), .got(got));
    task automatic chk(input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    always @(posedge clk) if (rd_ph && hready) chk(hrdata, rq.pop_front());
    always @(posedge clk) if (ack) chk(got, pq.pop_front());
    function automatic [31:0] rev(input logic [31:0] x);
        for (int k = 0; k < 32; k++) rev[k] = x[31-k];
    endfunction
    // reference kept in reflected form: q is crc_refl, not the bit-reversed register
    function automatic [31:0] upd(input logic [31:0] s, d, input int n);
        for (int k = 0; k < 8 * n; k++)
        begin
            if (k % 8 == 0) s ^= d[k+:8];
            s = s[0] ? (s >> 1) ^ `DCCRC_POLY : s >> 1;
        end
        return s;
    endfunction
    task automatic bus(input logic [7:0] a, input logic wr, [31:0] d);
        {hsel, haddr, hwrite, htrans} <= {1'b1, a, wr, 2'b10};
        do @(posedge clk); while (hready !== 1'b1);
        {htrans, hwdata, rd_ph} <= {2'b00, d, !wr};
        do @(posedge clk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic pulse(input logic [4:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        @(posedge clk);
    endtask
    task automatic send(input int n, input logic on);
        int b;
        repeat (n)
        begin
            b = $urandom_range(4, 1);
            w = $urandom;
            {dv, data, nb} <= {1'b1, w, b[2:0]};
            if (on) q = upd(q, w, b);
            @(posedge clk);
        end
        dv <= 1'b0;
        @(posedge clk);
    endtask
    task automatic post_end(input logic [3:0] d);
        dly <= d;
        pq.push_back(~q);
        pulse(5'h02);
    endtask
    task automatic wait_ack;
        for (i = 0; i < 40 && ack !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        void'($urandom(97));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 8'h1C; i <= 8'h34; i += 4)
            rd(i[7:0], i == 8'h24 ? 32'hFFFF_FFFF : 32'h0);
        bus(8'h34, 1'b1, 32'hFFFF_FFFF);
        rd(8'h34, 32'h0);
        w = $urandom;
        bus(8'h24, 1'b1, w);
        rd(8'h24, ~rev(w));
        $display("test map and load done");
        q = 32'hFFFF_FFFF;
        bus(8'h24, 1'b1, q);
        bus(8'h20, 1'b1, 32'hFFFF_FFFF);
        rd(8'h20, 32'h3);
        bus(8'h30, 1'b1, 32'h3);
        pulse(5'h01);
        send(6, 1'b1);
        post_end(4'h9);
        rd(8'h28, 32'hB);
        pulse(5'h02);
        wait_ack;
        rd(8'h28, 32'h5);
        chk({31'h0, irq}, 32'h1);
        rd(8'h2C, 32'h3);
        bus(8'h2C, 1'b1, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("test post done");
        pulse(5'h01);
        rd(8'h28, 32'h0);
        send(3, 1'b1);
        post_end(4'h0);
        wait_ack;
        rd(8'h24, ~q);
        w = ~q;
        bus(8'h24, 1'b1, ~rev(w));
        rd(8'h24, w);
        $display("test chain done");
        bus(8'h20, 1'b1, 32'h2);
        bus(8'h30, 1'b1, 32'h0);
        for (i = 2; i < 5; i++)
        begin
            pulse(5'h01);
            send(2, 1'b0);
            pulse(5'h02 | (5'h01 << i));
            rd(8'h28, 32'h1);
            bus(8'h20, 1'b1, 32'h2);
        end
        rd(8'h24, ~q);
        chk({31'h0, irq}, 32'h0);
        bus(8'h30, 1'b1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        $display("test forced end done");
        complete_run;
    end
    initial
    begin
        #200us;
        n_mismatch++;
        complete_run;
    end
endmodule // tb
`default_nettype wire
